// ---- verif/scu_apb_host.sv ----
// apb host model standing for the remote controller
// assumes the bench calls xfer from one process at a time
`timescale 1ns/10ps
`default_nettype none
module scu_apb_host
(
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // byte address
  output logic      [31:0] pwdata,  // write data
  output logic             hang,    // no answer within the bound
  input  wire logic        pclk,    // clock
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hang = 1'b0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rq,
                      output logic re);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (!pready && k < 40);
    hang = !pready;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not keep looking valid
    pwdata <= ~d;
  endtask : xfer
endmodule : scu_apb_host
`default_nettype wire

// ---- verif/scu_system_cmd_sva.sv ----
// assertions for scu_system_cmd, bound to its top-level ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "scu_consts.svh"
module scu_system_cmd_sva
(
  input wire logic                   pclk,       // clock
  input wire logic                   presetn,    // reset, active low
  input wire logic                   psel,       // apb select
  input wire logic                   penable,    // apb access
  input wire logic                   pwrite,     // apb write
  input wire logic [11:0]            paddr,      // apb address
  input wire logic [31:0]            pwdata,     // apb write data
  input wire logic                   pready,     // apb ready
  input wire logic                   meas_start, // measurement begins
  input wire logic                   meas_done,  // result valid
  input wire scu_pkg::scu_judge_type judge_in,   // new judgement
  input wire scu_pkg::scu_judge_type judge_out,  // latched judgement
  input wire logic [2:0]             brightness, // display level
  input wire logic                   beeper_en,  // beeper on
  input wire logic                   remote_en   // remote active
);
  import scu_pkg::*;
  logic       ctrl_wr;
  logic       ctrl_ok;
  logic       cmd_local;
  logic [2:0] w_bright;
  logic       w_beep;
  logic       hold_q;
  logic       busy_q;
  assign ctrl_wr   = psel && penable && pready && pwrite
                     && paddr == `SCU_OFF_CTRL;
  assign cmd_local = psel && penable && pready && pwrite
                     && paddr == `SCU_OFF_CMD && pwdata[0];
  assign w_bright  = pwdata[2:0];
  assign w_beep    = pwdata[4];
  assign ctrl_ok   = w_bright >= 3'h1 && w_bright <= 3'h5;
  // policy and phase are not ports, so they are mirrored here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 1'b0;
    else if (ctrl_wr && ctrl_ok)
      hold_q <= pwdata[8];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else if (meas_start && !busy_q)
      busy_q <= 1'b1;
    else if (meas_done && busy_q)
      busy_q <= 1'b0;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  bright_range_a:
    assert property (brightness >= 3'h1 && brightness <= 3'h5)
    else $error("brightness outside one to five");
  bright_write_a:
    assert property (ctrl_wr && ctrl_ok |=> brightness == $past(w_bright))
    else $error("brightness did not take the written level");
  beep_write_a:
    assert property (ctrl_wr && ctrl_ok |=> beeper_en == $past(w_beep))
    else $error("beeper enable did not take the written value");
  range_keep_a:
    assert property (ctrl_wr && !ctrl_ok
                     |=> $stable(brightness) && $stable(beeper_en))
    else $error("rejected control word changed a setting");
  local_cmd_a:
    assert property (cmd_local |=> !remote_en)
    else $error("remote still active after local command");
  clear_drop_a:
    assert property (meas_start && !busy_q && !hold_q |=> judge_out == '0)
    else $error("judgement not dropped at start in clear policy");
  hold_keep_a:
    assert property (meas_start && !busy_q && hold_q |=> $stable(judge_out))
    else $error("judgement changed at start in hold policy");
  judge_take_a:
    assert property (meas_done && busy_q |=> judge_out == $past(judge_in))
    else $error("judgement not updated from the result");
endmodule : scu_system_cmd_sva
bind scu_system_cmd scu_system_cmd_sva chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .meas_start(meas_start), .meas_done(meas_done), .judge_in(judge_in),
  .judge_out(judge_out), .brightness(brightness), .beeper_en(beeper_en),
  .remote_en(remote_en)
);
`default_nettype wire

// ---- verif/scu_system_cmd_tb.sv ----
// self-checking bench for scu_system_cmd through an apb host model
// assumes the checker is bound to the design from its own file
`timescale 1ns/10ps
`default_nettype none
`include "scu_consts.svh"
module scu_system_cmd_tb;
  import scu_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          hang, meas_start, meas_done, beeper_en, remote_en, irq;
  logic          err, hold;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, q, r;
  logic [79:0]   ver;
  logic [2:0]    brightness;
  logic [1:0]    user_pin;
  logic [13:0]   pw [2];
  logic [13:0]   w;
  scu_judge_type judge_in, judge_out, jm;
  int            miscompares, checks, seed, n;
  scu_system_cmd uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_start(meas_start),
    .meas_done(meas_done), .judge_in(judge_in), .judge_out(judge_out),
    .user_pin(user_pin), .brightness(brightness), .beeper_en(beeper_en),
    .remote_en(remote_en), .irq(irq)
  );
  scu_apb_host host
  (
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .hang(hang), .pclk(pclk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wd, input logic [11:0] a,
                     input logic [31:0] d);
    host.xfer(wd, a, d, q, err);
    if (hang)
    begin
      miscompares++;
      wrap_up();
    end
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic expect_rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : expect_rd
  // registered ports land after the write edge, so give them time
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  function automatic logic level(input logic [13:0] pv, scu_judge_type j);
    logic a, b, v;
    a = j[pv[7:4] - 4'h1];
    b = j[pv[11:8] - 4'h1];
    v = (pv[13:12] == 2'h1) ? a : (pv[13:12] == 2'h2) ? (a & b) : (a | b);
    return (pv[1:0] == 2'h1) ? !v : v;
  endfunction : level
  task automatic measure(input scu_judge_type j);
    @(posedge pclk);
    meas_start <= 1'b1;
    @(posedge pclk);
    meas_start <= 1'b0;
    if (!hold)
      jm = '0;
    #1 check(judge_out, jm);
    @(posedge pclk);
    meas_done <= 1'b1;
    judge_in <= j;
    @(posedge pclk);
    meas_done <= 1'b0;
    judge_in <= ~j;
    jm = j;
    settle();
    check(judge_out, jm);
    expect_rd(`SCU_OFF_JUDGE, {19'h0, jm});
    check(user_pin, {level(pw[1], jm), level(pw[0], jm)});
  endtask : measure
  initial
  begin
    seed = 32'hEFBAA977;
    presetn = 1'b0;
    meas_start = 1'b0;
    meas_done = 1'b0;
    judge_in = '0;
    hold = 1'b0;
    jm = '0;
    pw[0] = 14'h1DC2;
    pw[1] = 14'h1DC2;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    expect_rd(`SCU_OFF_PIN1, 32'h0000_1DC2);
    wr(`SCU_OFF_STR_SEL, 32'h0000_0200);
    expect_rd(`SCU_OFF_STR_DATA, 32'h0000_084E);
    expect_rd(`SCU_OFF_ERR, 32'h0);
    n = 3;
    for (int b = 0; b <= 7; b++)
    begin
      wr(`SCU_OFF_CTRL, {27'h0, b[0], 1'b0, b[2:0]});
      if (b >= 1 && b <= 5)
        n = b;
      expect_rd(`SCU_OFF_CTRL, {27'h0, n[0], 1'b0, n[2:0]});
      check(brightness, n[2:0]);
      check(beeper_en, n[0]);
    end
    expect_rd(`SCU_OFF_STR_DATA, 32'h0000_1144);
    expect_rd(`SCU_OFF_ERR, 32'h0000_FF22);
    expect_rd(`SCU_OFF_ERR, 32'h0);
    $display("settings and errors done");
    n = 0;
    for (int i = 0; i <= 31; i++)
    begin
      wr(`SCU_OFF_STR_SEL, {27'h0, i[4:0]});
      bus(1'b0, `SCU_OFF_STR_DATA, 32'h0);
      check(q[15:8], 8'h1F);
      if (q[7:0] == 8'h2C)
        n++;
    end
    check(q, 32'h0000_1F00);
    check(n, 3);
    ver = "SCPI1994.0";
    for (int i = 0; i < 10; i++)
    begin
      wr(`SCU_OFF_STR_SEL, 32'h100 + i);
      expect_rd(`SCU_OFF_STR_DATA, {16'h0, 8'h0A, ver[8*(9-i) +: 8]});
    end
    $display("reply strings done");
    wr(`SCU_OFF_STATUS, 32'h7);
    wr(`SCU_OFF_MASK, 32'h4);
    wr(`SCU_OFF_CMD, 32'h2);
    settle();
    check({remote_en, irq}, 2'b10);
    wr(`SCU_OFF_CMD, 32'h1);
    settle();
    check({remote_en, irq}, 2'b01);
    expect_rd(`SCU_OFF_STATUS, 32'h4);
    expect_rd(`SCU_OFF_MASK, 32'h4);
    wr(`SCU_OFF_STATUS, 32'h4);
    settle();
    check(irq, 1'b0);
    bus(1'b0, 12'h100, 32'h0);
    check(err, 1'b1);
    check(q, 32'h0);
    $display("local command and interrupt done");
    for (int k = 0; k < 24; k++)
    begin
      r = $random(seed);
      w[13:12] = (r[1:0] == 2'h0) ? 2'h1 : r[1:0];
      w[11:8] = (r[11:8] % 4'hD) + 4'h1;
      w[7:4] = (k % 5 == 4) ? (r[3] ? 4'h0 : 4'hE) : (r[7:4] % 4'hD) + 4'h1;
      w[3:0] = {2'h0, r[2] ? 2'h2 : 2'h1};
      wr(k[0] ? `SCU_OFF_PIN1 : `SCU_OFF_PIN0, {18'h0, w});
      if (k % 5 != 4)
        pw[k[0]] = w;
      expect_rd(k[0] ? `SCU_OFF_PIN1 : `SCU_OFF_PIN0,
                {18'h0, pw[k[0]]});
      hold = r[16];
      wr(`SCU_OFF_CTRL, {23'h0, hold, 8'h13});
      measure(r[31:19]);
    end
    $display("user pins and policies done");
    wrap_up();
  end
endmodule : scu_system_cmd_tb
`default_nettype wire

// ---- verilog/scu_consts.svh ----
// constants for the system command and user pin block: register offsets,
// field positions, reset values, codes and string lengths
// assumes a 12-bit APB byte address and 32-bit data
`ifndef SCU_CONSTS_SVH
`define SCU_CONSTS_SVH

// register byte offsets
`define SCU_OFF_CTRL      12'h000
`define SCU_OFF_PIN0      12'h004
`define SCU_OFF_PIN1      12'h008
`define SCU_OFF_ERR       12'h00C
`define SCU_OFF_STR_SEL   12'h010
`define SCU_OFF_STR_DATA  12'h014
`define SCU_OFF_STATUS    12'h018
`define SCU_OFF_MASK      12'h01C
`define SCU_OFF_JUDGE     12'h020
`define SCU_OFF_CMD       12'h024

// control register fields
`define SCU_CTRL_BRIGHT   2:0
`define SCU_CTRL_BEEP     4
`define SCU_CTRL_HOLD     8
`define SCU_CTRL_REMOTE   12

// user pin register fields
`define SCU_PIN_POL       1:0
`define SCU_PIN_FIRST     7:4
`define SCU_PIN_SECOND    11:8
`define SCU_PIN_OP        13:12

// string select register fields, string data fields
`define SCU_SEL_IDX       4:0
`define SCU_SEL_STR       9:8
`define SCU_DATA_CHAR     7:0
`define SCU_DATA_LEN      15:8

// command register bits
`define SCU_CMD_LOCAL     0
`define SCU_CMD_REMOTE    1

// status and mask bits
`define SCU_ST_ERR        0
`define SCU_ST_JUDGE      1
`define SCU_ST_LOCAL      2
`define SCU_ST_WIDTH      3

// value ranges
`define SCU_BRIGHT_MIN    3'h1
`define SCU_BRIGHT_MAX    3'h5
`define SCU_POL_LOW       2'h1
`define SCU_POL_HIGH      2'h2
`define SCU_CODE_MIN      4'h1
`define SCU_CODE_MAX      4'hD
`define SCU_OP_FIRST      2'h1
`define SCU_OP_AND        2'h2
`define SCU_OP_OR         2'h3

// reset values
`define SCU_RST_BRIGHT    3'h3
`define SCU_RST_BEEP      1'h1
`define SCU_RST_HOLD      1'h0
`define SCU_RST_POL       2'h2
`define SCU_RST_FIRST     4'hC
`define SCU_RST_SECOND    4'hD
`define SCU_RST_OP        2'h1
`define SCU_RST_MASK      3'h0

// error numbers, 16-bit two's complement
`define SCU_ERR_NONE      16'h0000
`define SCU_ERR_RANGE     16'hFF22

// string selectors and lengths
`define SCU_STR_IDN       2'h0
`define SCU_STR_VER       2'h1
`define SCU_STR_ERRMSG    2'h2
`define SCU_LEN_IDN       8'h1F
`define SCU_LEN_VER       8'h0A
`define SCU_LEN_NOERR     8'h08
`define SCU_LEN_RANGE     8'h11

`endif

// ---- verilog/scu_pkg.sv ----
// types shared by the system command block and its string store
// assumes scu_consts.svh for all other numeric values; type widths and state codes are set here
`default_nettype none
package scu_pkg;
  typedef logic [12:0] scu_judge_type;
  typedef logic [3:0]  scu_code_type;
  typedef logic [1:0]  scu_str_type;
  typedef enum logic [1:0]
  {
    SCU_MEAS_IDLE = 2'b01,
    SCU_MEAS_BUSY = 2'b10
  } scu_meas_state_type;
endpackage : scu_pkg
`default_nettype wire

// ---- verilog/scu_string_rom.sv ----
// fixed reply strings: identity, command-language version, error message
// assumes the caller registers the character it reads
`timescale 1ns/10ps
`default_nettype none
`include "scu_consts.svh"
module scu_string_rom
#(
  // identity text is arbitrary, 31 characters
  parameter logic [247:0] ID_TEXT = "ACME,MODEL-0001,S000000000,V1.0"
)
(
  input  wire logic [1:0]   sel,       // which string
  input  wire logic [4:0]   idx,       // character index from the left
  input  wire logic         err_busy,  // an error is pending
  output logic      [7:0]   char_out,  // character, zero past the end
  output logic      [7:0]   len_out    // length of the selected string
);
  import scu_pkg::*;

  localparam logic [79:0]  VER_TEXT   = "SCPI1994.0";
  localparam logic [63:0]  NOERR_TEXT = "No error";
  localparam logic [135:0] RANGE_TEXT = "Data out of range";

  function automatic logic [7:0] pick(input logic [247:0] text,
                                      input logic [7:0]   len,
                                      input logic [4:0]   i);
    logic [7:0] pos;
    pos = len - 8'h01 - {3'h0, i};
    if ({3'h0, i} >= len)
      pick = 8'h00;
    else
      pick = text[{pos[4:0], 3'h0} +: 8];
  endfunction : pick

  always_comb
  begin
    char_out = 8'h00;
    len_out  = 8'h00;
    unique case (sel)
      `SCU_STR_IDN:
      begin
        len_out  = `SCU_LEN_IDN;
        char_out = pick(ID_TEXT, `SCU_LEN_IDN, idx);
      end
      `SCU_STR_VER:
      begin
        len_out  = `SCU_LEN_VER;
        char_out = pick({168'h0, VER_TEXT}, `SCU_LEN_VER, idx);
      end
      `SCU_STR_ERRMSG:
      begin
        if (err_busy)
        begin
          len_out  = `SCU_LEN_RANGE;
          char_out = pick({112'h0, RANGE_TEXT}, `SCU_LEN_RANGE, idx);
        end
        else
        begin
          len_out  = `SCU_LEN_NOERR;
          char_out = pick({184'h0, NOERR_TEXT}, `SCU_LEN_NOERR, idx);
        end
      end
      default:
      begin
        len_out  = 8'h00;
        char_out = 8'h00;
      end
    endcase
  end
endmodule : scu_string_rom
`default_nettype wire

// ---- verilog/scu_system_cmd.sv ----
// system command settings and two user-defined handler pins, on APB
// assumes measurement logic on pclk gives start/done pulses and a
// one-hot-per-state judgement vector (bins 1..8, bin-out, hi, lo, pass, fail)
`timescale 1ns/10ps
`default_nettype none
`include "scu_consts.svh"
module scu_system_cmd
(
  input  wire logic                  pclk,        // clock, 100 MHz
  input  wire logic                  presetn,     // async reset, active low
  input  wire logic                  psel,        // apb select
  input  wire logic                  penable,     // apb access phase
  input  wire logic                  pwrite,      // apb write
  input  wire logic [11:0]           paddr,       // apb byte address
  input  wire logic [31:0]           pwdata,      // apb write data
  output logic      [31:0]           prdata,      // apb read data
  output logic                       pready,      // apb ready
  output logic                       pslverr,     // apb error, unmapped
  input  wire logic                  meas_start,  // measurement begins
  input  wire logic                  meas_done,   // measurement result valid
  input  wire scu_pkg::scu_judge_type judge_in,   // new judgement states
  output var scu_pkg::scu_judge_type judge_out,   // latched judgement
  output logic      [1:0]            user_pin,    // user pin levels
  output logic      [2:0]            brightness,  // display level 1..5
  output logic                       beeper_en,   // keyclick beeper on
  output logic                       remote_en,   // remote control active
  output logic                       irq          // interrupt, active high
);
  import scu_pkg::*;

  // settings
  logic               hold_mode;
  logic [1:0]         pol       [2];
  scu_code_type       first_judgement_operand  [2];
  scu_code_type       second_judgement_operand [2];
  logic [1:0]         op        [2];
  logic [15:0]        err_code;
  logic               err_busy;
  logic [1:0]         str_sel;
  logic [4:0]         str_idx;
  logic [`SCU_ST_WIDTH-1:0] status;
  logic [`SCU_ST_WIDTH-1:0] mask;
  scu_meas_state_type meas_state;

  // bus decode
  logic        setup_ok;
  logic        done_edge;
  logic        wr_now;
  logic        rd_now;
  logic [31:0] next_rdata;
  logic        hit;
  logic        bad_value;
  logic [7:0]  rom_char;
  logic [7:0]  rom_len;
  logic        judge_evt;
  logic        local_evt;
  logic        err_evt;

  function automatic logic code_ok(input scu_code_type c);
    code_ok = (c >= `SCU_CODE_MIN) && (c <= `SCU_CODE_MAX);
  endfunction : code_ok

  function automatic logic pin_word_ok(input logic [31:0] w);
    pin_word_ok = ((w[`SCU_PIN_POL] == `SCU_POL_LOW) ||
                   (w[`SCU_PIN_POL] == `SCU_POL_HIGH)) &&
                  code_ok(w[`SCU_PIN_FIRST]) &&
                  code_ok(w[`SCU_PIN_SECOND]) &&
                  (w[`SCU_PIN_OP] != 2'h0);
  endfunction : pin_word_ok

  // picks the judgement state named by a code 1..13
  function automatic logic pick_state(input scu_code_type  c,
                                      input scu_judge_type j);
    logic [3:0] i;
    i = c - `SCU_CODE_MIN;
    pick_state = code_ok(c) ? j[i] : 1'b0;
  endfunction : pick_state

  function automatic logic pin_level(input logic [1:0]    p,
                                     input scu_code_type  a,
                                     input scu_code_type  b,
                                     input logic [1:0]    o,
                                     input scu_judge_type j);
    logic r;
    r = pick_state(a, j);
    if (o == `SCU_OP_AND)
      r = r & pick_state(b, j);
    else if (o == `SCU_OP_OR)
      r = r | pick_state(b, j);
    pin_level = (p == `SCU_POL_LOW) ? ~r : r;
  endfunction : pin_level

  function automatic logic [31:0] pin_word(input logic [1:0]   p,
                                           input scu_code_type a,
                                           input scu_code_type b,
                                           input logic [1:0]   o);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SCU_PIN_POL]    = p;
    w[`SCU_PIN_FIRST]  = a;
    w[`SCU_PIN_SECOND] = b;
    w[`SCU_PIN_OP]     = o;
    pin_word = w;
  endfunction : pin_word

  assign setup_ok  = psel && penable && !pready;
  assign done_edge = psel && penable && pready && !pslverr;
  assign wr_now    = done_edge && pwrite;
  assign rd_now    = done_edge && !pwrite;

  scu_string_rom u_rom
  (
    .sel      (str_sel),
    .idx      (str_idx),
    .err_busy (err_busy),
    .char_out (rom_char),
    .len_out  (rom_len)
  );

  // range check of the word being written at its own address
  always_comb
  begin
    bad_value = 1'b0;
    if (paddr == `SCU_OFF_CTRL)
      bad_value = (pwdata[`SCU_CTRL_BRIGHT] < `SCU_BRIGHT_MIN) ||
                  (pwdata[`SCU_CTRL_BRIGHT] > `SCU_BRIGHT_MAX);
    else if ((paddr == `SCU_OFF_PIN0) || (paddr == `SCU_OFF_PIN1))
      bad_value = !pin_word_ok(pwdata);
  end

  always_comb
  begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      `SCU_OFF_CTRL:
      begin
        next_rdata[`SCU_CTRL_BRIGHT] = brightness;
        next_rdata[`SCU_CTRL_BEEP]   = beeper_en;
        next_rdata[`SCU_CTRL_HOLD]   = hold_mode;
        next_rdata[`SCU_CTRL_REMOTE] = remote_en;
      end
      `SCU_OFF_PIN0:
        next_rdata = pin_word(pol[0], first_judgement_operand[0],
                              second_judgement_operand[0], op[0]);
      `SCU_OFF_PIN1:
        next_rdata = pin_word(pol[1], first_judgement_operand[1],
                              second_judgement_operand[1], op[1]);
      `SCU_OFF_ERR:
        next_rdata = {16'h0000, err_code};
      `SCU_OFF_STR_SEL:
      begin
        next_rdata[`SCU_SEL_IDX] = str_idx;
        next_rdata[`SCU_SEL_STR] = str_sel;
      end
      `SCU_OFF_STR_DATA:
      begin
        next_rdata[`SCU_DATA_CHAR] = rom_char;
        next_rdata[`SCU_DATA_LEN]  = rom_len;
      end
      `SCU_OFF_STATUS:
        next_rdata[`SCU_ST_WIDTH-1:0] = status;
      `SCU_OFF_MASK:
        next_rdata[`SCU_ST_WIDTH-1:0] = mask;
      `SCU_OFF_JUDGE:
        next_rdata[12:0] = judge_out;
      `SCU_OFF_CMD:
        next_rdata = 32'h0000_0000;
      default:
        hit = 1'b0;
    endcase
  end

  // one wait state: the answer is registered, so prdata is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_ok;
      pslverr <= setup_ok && !hit;
      if (setup_ok && !pwrite)
        prdata <= hit ? next_rdata : 32'h0000_0000;
    end
  end

  // general settings; a rejected value keeps the old one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brightness <= `SCU_RST_BRIGHT;
      beeper_en  <= `SCU_RST_BEEP;
      hold_mode  <= `SCU_RST_HOLD;
    end
    else if (wr_now && (paddr == `SCU_OFF_CTRL) && !bad_value)
    begin
      brightness <= pwdata[`SCU_CTRL_BRIGHT];
      beeper_en  <= pwdata[`SCU_CTRL_BEEP];
      hold_mode  <= pwdata[`SCU_CTRL_HOLD];
    end
  end

  // user pin settings, whole word accepted or whole word refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < 2; k++)
      begin
        pol[k]                      <= `SCU_RST_POL;
        first_judgement_operand[k]  <= `SCU_RST_FIRST;
        second_judgement_operand[k] <= `SCU_RST_SECOND;
        op[k]                       <= `SCU_RST_OP;
      end
    end
    else
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (wr_now && !bad_value &&
            (paddr == ((k == 0) ? `SCU_OFF_PIN0 : `SCU_OFF_PIN1)))
        begin
          pol[k]                      <= pwdata[`SCU_PIN_POL];
          first_judgement_operand[k]  <= pwdata[`SCU_PIN_FIRST];
          second_judgement_operand[k] <= pwdata[`SCU_PIN_SECOND];
          op[k]                       <= pwdata[`SCU_PIN_OP];
        end
      end
    end
  end

  // error entry; a new error wins over the clearing read of the old one
  assign err_evt = wr_now && bad_value;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_code <= `SCU_ERR_NONE;
      err_busy <= 1'b0;
    end
    else if (err_evt)
    begin
      err_code <= `SCU_ERR_RANGE;
      err_busy <= 1'b1;
    end
    else if (rd_now && (paddr == `SCU_OFF_ERR))
    begin
      err_code <= `SCU_ERR_NONE;
      err_busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      str_sel <= `SCU_STR_IDN;
      str_idx <= 5'h00;
    end
    else if (wr_now && (paddr == `SCU_OFF_STR_SEL))
    begin
      str_sel <= pwdata[`SCU_SEL_STR];
      str_idx <= pwdata[`SCU_SEL_IDX];
    end
  end

  // remote/local; local wins when both bits are written together
  assign local_evt = wr_now && (paddr == `SCU_OFF_CMD) &&
                     pwdata[`SCU_CMD_LOCAL];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      remote_en <= 1'b0;
    else if (local_evt)
      remote_en <= 1'b0;
    else if (wr_now && (paddr == `SCU_OFF_CMD) && pwdata[`SCU_CMD_REMOTE])
      remote_en <= 1'b1;
  end

  // measurement tracking and judgement latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      meas_state <= SCU_MEAS_IDLE;
    else
    begin
      unique case (meas_state)
        SCU_MEAS_IDLE:
          if (meas_start)
            meas_state <= SCU_MEAS_BUSY;
        SCU_MEAS_BUSY:
          if (meas_done)
            meas_state <= SCU_MEAS_IDLE;
        default:
          meas_state <= SCU_MEAS_IDLE;
      endcase
    end
  end

  // a done pulse outside a measurement carries no result and is ignored
  assign judge_evt = (meas_state == SCU_MEAS_BUSY) && meas_done &&
                     (judge_in != judge_out);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      judge_out <= 13'h0000;
    else if (judge_evt)
      judge_out <= judge_in;
    else if (!hold_mode && (meas_state == SCU_MEAS_IDLE) && meas_start)
      judge_out <= 13'h0000;
  end

  // pins follow the latched judgement, so they inherit the latch policy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      user_pin <= 2'b00;
    else
    begin
      for (int k = 0; k < 2; k++)
        user_pin[k] <= pin_level(pol[k], first_judgement_operand[k],
                                 second_judgement_operand[k], op[k],
                                 judge_out);
    end
  end

  // sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= 3'h0;
    else
    begin
      if (wr_now && (paddr == `SCU_OFF_STATUS))
        status <= (status & ~pwdata[`SCU_ST_WIDTH-1:0]) |
                  {local_evt, judge_evt, err_evt};
      else
        status <= status | {local_evt, judge_evt, err_evt};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask <= `SCU_RST_MASK;
    else if (wr_now && (paddr == `SCU_OFF_MASK))
      mask <= pwdata[`SCU_ST_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end
endmodule : scu_system_cmd
`default_nettype wire
